// [shared/ocp_pkg.sv]
// How it works
// RULE_01: Zero duty with non-zero period keeps the output low all period.
// RULE_02: Duty above period keeps the output high all period.
// RULE_03: Equal non-zero duty and period give one low count, then high again.
// RULE_04: Sleep freezes the channel, holding the output level it had.
// RULE_05: After wake the channel resumes from its frozen state, no reconfiguration.
// RULE_06: Fault mode in sleep still detects faults, tri-states output, sets fault flag.
// RULE_07: Fault interrupt raised during sleep is held pending until wake.
// RULE_08: With idle halt set, idle stops the channel exactly like sleep.
// RULE_09: With idle halt clear, idle runs only if the selected timer runs.
// RULE_10: Enabled fault inputs keep control of the output in sleep and idle.
// RULE_11: Doze behaves exactly like normal operation.
// RULE_12: Peripheral clock gate ignores register writes and reads return zero.
// RULE_13: Enabled channel owns the pin direction, overriding the port direction.
// RULE_14: Disabled channel hands pin level and direction back to port latch.
// RULE_15: Fault mode never changes the fault pin direction.
// RULE_16: Fault input A serves channels one to four, input B channel five.
// RULE_17: Software keeps timer 32-bit concatenation off for a compare time base.
// RULE_18: Shadow duty copies into active duty only at a period match.
// RULE_19: Fault flag is read-only; clears after fault removal and mode rewrite.
// RULE_20: Period value N gives N plus one time-base counts.
// RULE_21: A detected fault sets the channel interrupt flag.
// RULE_22: Output level updates on the clock from registered compare results.
package ocp_pkg;
	localparam int unsigned ADDR_W   = 4;
	localparam logic [3:0]  CTRL_OFS = 4'h0;
	localparam logic [3:0]  DUTY_OFS = 4'h4;
	localparam logic [3:0]  SHAD_OFS = 4'h8;
	localparam int unsigned IDLE_BIT = 13;
	localparam int unsigned FLT_BIT  = 4;
	localparam int unsigned TSEL_BIT = 3;
	localparam logic [2:0]  MODE_OFF = 3'h0;
	localparam logic [2:0]  MODE_PWM = 3'h6;
	localparam logic [2:0]  MODE_FLT = 3'h7;
	localparam logic [15:0] DUTY_RST = 16'h0000;
	localparam logic [1:0]  RESP_OK  = 2'h0;
	localparam logic [1:0]  RESP_ERR = 2'h2;
	localparam int unsigned FLT_B_CH = 5;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] period;
		logic        idle_halt;
	} ocp_tmr_t;

	typedef struct packed {
		logic level;
		logic oe;
	} ocp_pin_t;
endpackage : ocp_pkg

// [src/ocp_pwm_chan.sv]
// The AXI4-Lite register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
module ocp_pwm_chan #(
	parameter int unsigned CHAN_NUM = 1
) (
	input  wire logic                       aclk,
	input  wire logic                       aresetn,
	input  wire logic [ocp_pkg::ADDR_W-1:0] s_axi_awaddr,
	input  wire logic                       s_axi_awvalid,
	output logic                            s_axi_awready,
	input  wire logic [31:0]                s_axi_wdata,
	input  wire logic [3:0]                 s_axi_wstrb,
	input  wire logic                       s_axi_wvalid,
	output logic                            s_axi_wready,
	output logic [1:0]                      s_axi_bresp,
	output logic                            s_axi_bvalid,
	input  wire logic                       s_axi_bready,
	input  wire logic [ocp_pkg::ADDR_W-1:0] s_axi_araddr,
	input  wire logic                       s_axi_arvalid,
	output logic                            s_axi_arready,
	output logic [31:0]                     s_axi_rdata,
	output logic [1:0]                      s_axi_rresp,
	output logic                            s_axi_rvalid,
	input  wire logic                       s_axi_rready,
	input  wire ocp_pkg::ocp_tmr_t          tmr_a,
	input  wire ocp_pkg::ocp_tmr_t          tmr_b,
	input  wire logic                       sleep_mode,
	input  wire logic                       idle_mode,
	input  wire logic                       peripheral_clock_gate,
	input  wire logic                       port_latch,
	input  wire logic                       port_direction,
	input  wire logic                       fault_in_a_n,
	input  wire logic                       fault_in_b_n,
	output ocp_pkg::ocp_pin_t               compare_out_pin,
	output logic                            fault_seen_flag,
	output logic                            channel_irq_flag
);
	logic [3:0]  awaddr_q;
	logic [15:0] wdata_q;
	logic [1:0]  wstrb_q;
	logic        wr_fire;
	logic        wr_hit;
	logic        gate;
	logic        idle_halt_ctl_q;
	logic        tsel_q;
	logic [2:0]  compare_mode_sel_q;
	logic [15:0] duty_compare_reg_q;
	logic [15:0] duty_shadow_reg_q;
	logic        mode_wr;
	logic        pwm_mode;
	ocp_pkg::ocp_tmr_t tmr;
	logic        halt;
	logic        run;
	logic [15:0] prev_cnt_q;
	logic        per_hit;
	logic        pwm_q;
	logic [1:0]  flt_n_s1_q;
	logic [1:0]  flt_n_s2_q;
	logic        flt;
	logic        irq_pend_q;

	function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
		input logic [1:0] strb);
		merge = {strb[1] ? nw[15:8] : old[15:8], strb[0] ? nw[7:0] : old[7:0]};
	endfunction : merge

	function automatic logic [15:0] ctrl_view(input logic ih, input logic fl, input logic ts,
		input logic [2:0] md);
		ctrl_view = '0;
		ctrl_view[ocp_pkg::IDLE_BIT] = ih;
		ctrl_view[ocp_pkg::FLT_BIT] = fl;
		ctrl_view[ocp_pkg::TSEL_BIT] = ts;
		ctrl_view[2:0] = md;
	endfunction : ctrl_view

	assign gate = peripheral_clock_gate;
	assign pwm_mode = (compare_mode_sel_q == ocp_pkg::MODE_PWM) ||
		(compare_mode_sel_q == ocp_pkg::MODE_FLT);
	assign tmr = tsel_q ? tmr_b : tmr_a;
	// Doze only slows the CPU, so it is not an input here at all [RULE_11]
	assign halt = sleep_mode || (idle_mode && (idle_halt_ctl_q || tmr.idle_halt)); // [RULE_08] [RULE_09]
	assign run = pwm_mode && !halt && !gate; // [RULE_04] [RULE_05]
	// Timer wraps after N, giving N+1 counts; a fresh match is seen once per period [RULE_20]
	assign per_hit = run && (tmr.count == tmr.period) && (tmr.count != prev_cnt_q);
	assign wr_fire = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;
	assign wr_hit = wr_fire && !gate;
	assign mode_wr = wr_hit && (awaddr_q == ocp_pkg::CTRL_OFS) && wstrb_q[0];

	// AXI4-Lite write: address and data taken in either order, response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= ocp_pkg::RESP_OK;
			awaddr_q      <= '0;
			wdata_q       <= '0;
			wstrb_q       <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awaddr_q      <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wdata_q      <= s_axi_wdata[15:0];
				wstrb_q      <= s_axi_wstrb[1:0];
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (awaddr_q == ocp_pkg::CTRL_OFS || awaddr_q == ocp_pkg::DUTY_OFS ||
					awaddr_q == ocp_pkg::SHAD_OFS) ? ocp_pkg::RESP_OK : ocp_pkg::RESP_ERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// AXI4-Lite read; a gated module answers zero
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= ocp_pkg::RESP_OK;
		end else begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rresp   <= ocp_pkg::RESP_OK;
				s_axi_rdata   <= '0;
				if (gate) begin
					s_axi_rdata <= '0; // [RULE_12]
				end else begin
					case (s_axi_araddr)
						ocp_pkg::CTRL_OFS: s_axi_rdata <= {16'h0000, ctrl_view(idle_halt_ctl_q,
							fault_seen_flag, tsel_q, compare_mode_sel_q)};
						ocp_pkg::DUTY_OFS: s_axi_rdata <= {16'h0000, duty_compare_reg_q};
						ocp_pkg::SHAD_OFS: s_axi_rdata <= {16'h0000, duty_shadow_reg_q};
						default:           s_axi_rresp <= ocp_pkg::RESP_ERR;
					endcase
				end
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
		end
	end

	// Control fields; gated writes are dropped [RULE_12]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			idle_halt_ctl_q    <= 1'b0;
			tsel_q             <= 1'b0;
			compare_mode_sel_q <= ocp_pkg::MODE_OFF;
		end else if (wr_hit && awaddr_q == ocp_pkg::CTRL_OFS) begin
			if (wstrb_q[1]) begin
				idle_halt_ctl_q <= wdata_q[ocp_pkg::IDLE_BIT];
			end
			if (wstrb_q[0]) begin
				tsel_q             <= wdata_q[ocp_pkg::TSEL_BIT];
				compare_mode_sel_q <= wdata_q[2:0];
			end
		end
	end

	// Duty is double buffered so a mid-period write cannot glitch the pin
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			duty_compare_reg_q <= ocp_pkg::DUTY_RST;
			duty_shadow_reg_q  <= ocp_pkg::DUTY_RST;
		end else begin
			if (wr_hit && awaddr_q == ocp_pkg::SHAD_OFS) begin
				duty_shadow_reg_q <= merge(duty_shadow_reg_q, wdata_q, wstrb_q);
			end
			if (per_hit) begin
				duty_compare_reg_q <= duty_shadow_reg_q; // [RULE_18]
			end else if (wr_hit && awaddr_q == ocp_pkg::DUTY_OFS && !pwm_mode) begin
				duty_compare_reg_q <= merge(duty_compare_reg_q, wdata_q, wstrb_q);
			end
		end
	end

	// One compare covers zero, full and equal duty: high while count below duty
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			prev_cnt_q <= '0;
			pwm_q      <= 1'b0;
		end else if (run) begin
			prev_cnt_q <= tmr.count;
			pwm_q <= (duty_compare_reg_q != 16'h0000) && (tmr.count < duty_compare_reg_q); // [RULE_01] [RULE_02] [RULE_03] [RULE_22]
		end
	end

	// Fault pins are only read, never driven [RULE_15]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flt_n_s1_q <= 2'h3;
			flt_n_s2_q <= 2'h3;
		end else begin
			flt_n_s1_q <= {fault_in_b_n, fault_in_a_n};
			flt_n_s2_q <= flt_n_s1_q;
		end
	end

	// Fault watch ignores halt so it keeps working in sleep and idle [RULE_06] [RULE_10]
	assign flt = !gate && (compare_mode_sel_q == ocp_pkg::MODE_FLT) &&
		!((CHAN_NUM == ocp_pkg::FLT_B_CH) ? flt_n_s2_q[1] : flt_n_s2_q[0]); // [RULE_16]

	// Set beats clear; clear needs fault gone plus a mode write [RULE_19]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			fault_seen_flag <= 1'b0;
		end else if (flt) begin
			fault_seen_flag <= 1'b1; // [RULE_06]
		end else if (mode_wr) begin
			fault_seen_flag <= 1'b0;
		end
	end

	// Interrupt waits while asleep and is delivered on wake [RULE_07] [RULE_21]
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_pend_q       <= 1'b0;
			channel_irq_flag <= 1'b0;
		end else begin
			channel_irq_flag <= irq_pend_q && !sleep_mode;
			if (flt && !fault_seen_flag) begin
				irq_pend_q <= 1'b1;
			end else if (!sleep_mode) begin
				irq_pend_q <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			compare_out_pin <= '0;
		end else if (compare_mode_sel_q == ocp_pkg::MODE_OFF) begin
			compare_out_pin.level <= port_latch; // [RULE_14]
			compare_out_pin.oe    <= !port_direction;
		end else begin
			compare_out_pin.oe <= !flt; // [RULE_13] [RULE_06]
			if (run) begin
				compare_out_pin.level <= pwm_q; // [RULE_22]
			end
		end
	end

	a_zero_duty_low: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_01]
		run && duty_compare_reg_q == 16'h0000 |=> !pwm_q)
		else $error("zero duty did not give low output");
	a_full_duty_high: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_02]
		run && duty_compare_reg_q > tmr.period && tmr.count <= tmr.period |=> pwm_q)
		else $error("duty above period did not give high output");
	a_equal_duty_high: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_03]
		run && duty_compare_reg_q == tmr.period && tmr.period != 16'h0000 &&
		tmr.count < tmr.period |=> pwm_q)
		else $error("equal duty output low outside the last count");
	a_sleep_level_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_04]
		sleep_mode && compare_mode_sel_q != ocp_pkg::MODE_OFF ##1 sleep_mode &&
		compare_mode_sel_q != ocp_pkg::MODE_OFF |=> $stable(compare_out_pin.level))
		else $error("output level moved during sleep");
	a_fault_tristate: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_06]
		flt && compare_mode_sel_q != ocp_pkg::MODE_OFF |=> !compare_out_pin.oe && fault_seen_flag)
		else $error("fault did not tri-state output and set flag");
	a_sleep_irq_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
		sleep_mode |=> !channel_irq_flag)
		else $error("interrupt raised during sleep");
	a_irq_on_wake: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_07]
		irq_pend_q && !sleep_mode |=> channel_irq_flag)
		else $error("pending interrupt not delivered on wake");
	a_idle_halt_run: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_08]
		idle_mode && idle_halt_ctl_q |-> !run)
		else $error("channel ran in idle with idle halt set");
	a_gate_read_zero: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
		s_axi_arvalid && s_axi_arready && gate |=> s_axi_rvalid && s_axi_rdata == 32'h00000000)
		else $error("gated read returned non-zero");
	a_shadow_load: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_18]
		per_hit |=> duty_compare_reg_q == $past(duty_shadow_reg_q))
		else $error("shadow duty not loaded at period match");
	// The release edge still loads reset values, so it cannot start an attempt
	a_disabled_pin: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_14]
		aresetn && compare_mode_sel_q == ocp_pkg::MODE_OFF |=>
		compare_out_pin.level == $past(port_latch) && compare_out_pin.oe == !$past(port_direction))
		else $error("disabled channel did not follow port latch");
	a_gate_write_drop: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_12]
		wr_fire && gate |=> $stable(duty_shadow_reg_q) && $stable(compare_mode_sel_q))
		else $error("gated write changed a register");
	a_pin_owned: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_13]
		compare_mode_sel_q != ocp_pkg::MODE_OFF && !flt |=> compare_out_pin.oe)
		else $error("enabled channel did not own the pin");
	a_flag_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_19]
		fault_seen_flag && !mode_wr |=> fault_seen_flag)
		else $error("fault flag cleared without a mode write");
	a_idle_timer_halt: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_09]
		idle_mode && tmr.idle_halt |-> !run)
		else $error("channel ran in idle with its timer halted");
	a_irq_one_pulse: assert property (@(posedge aclk) disable iff (!aresetn) // [RULE_21]
		channel_irq_flag |=> !channel_irq_flag)
		else $error("fault interrupt longer than one cycle");
endmodule : ocp_pwm_chan

// [testbench/ocp_load_model.sv]
`timescale 1ns/1ps
module ocp_load_model (
	input  wire ocp_pkg::ocp_pin_t pin,
	input  wire logic [1:0]        fault_req,
	output logic [1:0]             fault_n,
	output logic                   pin_wire
);
	// Fault lines are open-drain with pull-ups, so a released line reads high
	assign fault_n = ~fault_req;
	// The load pulls a released compare pin low, so a tri-state never reads as a drive
	assign pin_wire = pin.oe ? pin.level : 1'b0;
endmodule : ocp_load_model

// [testbench/ocp_pwm_chan_tb.sv]
`timescale 1ns/1ps
module ocp_pwm_chan_tb;
	logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
	logic              awready, wready, bvalid, arready, rvalid, flag, irq, pin_wire;
	logic              sleep, idle, gate, latch, dirn, tih, tib;
	logic [3:0]        awaddr, araddr, wstrb;
	logic [31:0]       wdata, rdata, d;
	logic [1:0]        bresp, rresp, flt_req, flt_n, r;
	logic [15:0]       cnt = 16'h0000;
	logic [15:0]       per = 16'h0008;
	logic [15:0]       cur;
	ocp_pkg::ocp_pin_t pin;
	int                fail_count, checked, hi, ch;
	int                irqs = 0;

	ocp_pwm_chan u_ocp_pwm_chan (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
		.s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .tmr_a({cnt, per, tih}), .tmr_b({cnt, per, tib}),
		.sleep_mode(sleep), .idle_mode(idle), .peripheral_clock_gate(gate),
		.port_latch(latch), .port_direction(dirn), .fault_in_a_n(flt_n[0]),
		.fault_in_b_n(flt_n[1]), .compare_out_pin(pin), .fault_seen_flag(flag),
		.channel_irq_flag(irq));
	ocp_load_model u_ocp_load_model (.pin(pin), .fault_req(flt_req), .fault_n(flt_n),
		.pin_wire(pin_wire));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	// Free-running 16-bit time base, never concatenated; the channel decides to follow
	always @(posedge aclk) begin
		cnt <= (cnt >= per) ? 16'h0000 : cnt + 16'h0001;
		if (irq === 1'b1) irqs <= irqs + 1;
	end

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			fail_count++;
			$display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
		end
	endtask : chk

	task automatic close_out;
		$display("Counts: checked %0d fail_count %0d", checked, fail_count);
		if (fail_count == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out

	task automatic wr(input logic [3:0] a, input logic [15:0] v);
		int n;
		n = 0;
		awaddr  <= a;
		wdata   <= {16'h0000, v};
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!(bvalid === 1'b1) && n < 100);
		if (n >= 100) fail_count++;
		bready <= 1'b0;
		chk("write resp", bresp, ocp_pkg::RESP_OK);
		// An idle edge keeps the next call from reassigning bready in this step
		@(posedge aclk);
	endtask : wr

	task automatic rd(input logic [3:0] a);
		int n;
		n = 0;
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!(rvalid === 1'b1) && n < 100);
		if (n >= 100) fail_count++;
		d = rdata;
		r = rresp;
		rready <= 1'b0;
		@(posedge aclk);
	endtask : rd

	task automatic rdchk(input string nm, input logic [3:0] a, input logic [15:0] exp);
		rd(a);
		chk(nm, d, {16'h0000, exp});
		chk("read resp", r, ocp_pkg::RESP_OK);
	endtask : rdchk

	// Counts high cycles and level changes over one full period of the pin
	task automatic meas;
		logic p;
		hi = 0;
		ch = 0;
		@(posedge aclk);
		p = pin_wire;
		repeat (per + 1) begin
			@(posedge aclk);
			hi += (pin_wire === 1'b1);
			ch += (pin_wire !== p);
			p = pin_wire;
		end
	endtask : meas

	function automatic int exp_hi(input logic [15:0] dv, input logic [15:0] p);
		if (dv == 16'h0000) return 0;
		if (dv > p) return p + 1;
		return dv;
	endfunction : exp_hi

	// Two periods cover the shadow load at the match plus the pin latency
	task automatic run_chk(input string nm);
		repeat (2 * per + 6) @(posedge aclk);
		meas();
		chk(nm, hi, exp_hi(cur, per));
	endtask : run_chk

	task automatic frz(input string nm);
		repeat (3) @(posedge aclk);
		meas();
		chk(nm, ch, 0);
	endtask : frz

	task automatic pwm(input logic [15:0] v, input string nm);
		wr(ocp_pkg::SHAD_OFS, v);
		cur = v;
		run_chk(nm);
	endtask : pwm

	initial begin
		void'($urandom(43));
		{aresetn, awvalid, wvalid, bready, arvalid, rready, sleep, idle, gate} = '0;
		{latch, dirn, tih, tib, flt_req, awaddr, araddr, wdata} = '0;
		wstrb = 4'h3;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		latch   <= 1'b1;
		repeat (3) @(posedge aclk);
		chk("gpio drive", pin, 2'b11);
		dirn  <= 1'b1;
		latch <= 1'b0;
		repeat (3) @(posedge aclk);
		chk("gpio input", pin, 2'b00);
		rd(4'hC);
		chk("unmapped resp", r, ocp_pkg::RESP_ERR);
		rdchk("ctrl reset", ocp_pkg::CTRL_OFS, 16'h0000);
		per <= 16'(8 + $urandom % 24);
		wr(ocp_pkg::CTRL_OFS, {13'h0000, ocp_pkg::MODE_PWM});
		repeat (3) @(posedge aclk);
		chk("pin owned", pin.oe, 1'b1);
		pwm(16'h0000, "zero duty");
		pwm(per, "equal duty");
		pwm(16'(per + 1 + $urandom % 100), "full duty");
		for (int i = 0; i < 4; i++) begin
			pwm(16'(1 + $urandom % per), "duty count");
		end
		wr(ocp_pkg::DUTY_OFS, 16'h1234);
		rdchk("duty read only", ocp_pkg::DUTY_OFS, cur);
		per <= 16'h0028;
		for (int n = 0; n < 200 && cnt != 16'h0001; n++) @(posedge aclk);
		wr(ocp_pkg::SHAD_OFS, 16'h0015);
		rdchk("duty before match", ocp_pkg::DUTY_OFS, cur);
		repeat (per + 2) @(posedge aclk);
		rdchk("duty after match", ocp_pkg::DUTY_OFS, 16'h0015);
		cur = 16'h0015;
		repeat ($urandom % per) @(posedge aclk);
		sleep <= 1'b1;
		frz("sleep frozen");
		sleep <= 1'b0;
		run_chk("wake resume");
		wr(ocp_pkg::CTRL_OFS, 16'h2006);
		idle <= 1'b1;
		frz("idle halted");
		wr(ocp_pkg::CTRL_OFS, 16'h0006);
		run_chk("idle runs");
		tib <= 1'b1;
		wr(ocp_pkg::CTRL_OFS, 16'h000E);
		frz("idle timer b");
		idle <= 1'b0;
		run_chk("timer b runs");
		gate <= 1'b1;
		wr(ocp_pkg::SHAD_OFS, 16'h0003);
		rdchk("gated read", ocp_pkg::SHAD_OFS, 16'h0000);
		frz("gated frozen");
		gate <= 1'b0;
		rdchk("gated write", ocp_pkg::SHAD_OFS, cur);
		wr(ocp_pkg::CTRL_OFS, 16'h000F);
		flt_req <= 2'b10;
		repeat (6) @(posedge aclk);
		chk("other fault", {pin.oe, flag}, 2'b10);
		flt_req <= 2'b00;
		wr(ocp_pkg::CTRL_OFS, 16'h0007);
		sleep   <= 1'b1;
		flt_req <= 2'b01;
		repeat (6) @(posedge aclk);
		chk("fault tristate", {pin.oe, flag}, 2'b01);
		chk("irq held", irqs, 0);
		sleep <= 1'b0;
		repeat (4) @(posedge aclk);
		chk("irq on wake", irqs, 1);
		rdchk("flag in ctrl", ocp_pkg::CTRL_OFS, 16'h0017);
		wr(ocp_pkg::CTRL_OFS, 16'h0007);
		chk("flag held", flag, 1'b1);
		flt_req <= 2'b00;
		repeat (4) @(posedge aclk);
		wr(ocp_pkg::CTRL_OFS, 16'h0007);
		repeat (2) @(posedge aclk);
		chk("flag cleared", {pin.oe, flag}, 2'b10);
		close_out();
	end

	// Whole run needs under two thousand cycles; this allows many times that
	initial begin
		#500000;
		fail_count++;
		close_out();
	end
endmodule : ocp_pwm_chan_tb
